/* fault_supervisor.sv */
// Local design decisions: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
// Behaviour
// - no fault: both open-drain flags released, pull-ups read high
// - vcc1 or vcc2 under-voltage drives supply flag low only
// - vcc2 over-voltage drives supply flag low only
// - over-voltage stops primary switch drive, resumes when it ends
// - over-voltage leaves gate, clamp, desat and soft shutdown untouched
// - short circuit: soft shutdown active, desat flag low only
// - secondary pulses heartbeat when span ok; missing pulses mean channel fault
// - channel fault forces switch drive and comp low, both flags low
// - channel fault latched until primary power cycle (reset)
// - gate output follows the led input
// - miller clamp on while gate below clamp threshold
// - vcc2 under-voltage forces gate low regardless of led
// - vcc2 above rising threshold clears lockout and resumes automatically
// - desat detection disabled for the whole blanking interval after turn-on
// - blanking equals internal time plus programmed external portion
// - desat trip after blanking: soft shutdown, gate output high impedance
// - during mute led ignored and gate output high impedance
// - on reset condition desat flag and soft shutdown released
// - gate follows led again only after short circuit fault clears
module fault_supervisor
  import fault_sup_pkg::*;
(
  input wire logic pclk,  // 100 MHz clock
  input wire logic presetn,  // async reset, active low (primary power cycle)
  input wire logic ce,  // clock enable, freezes all state when low
  input wire logic psel,  // apb select
  input wire logic penable,  // apb enable
  input wire logic pwrite,  // apb write
  input wire logic [11:0] paddr,  // apb byte address
  input wire logic [31:0] pwdata,  // apb write data
  output logic [31:0] prdata,  // apb read data
  output logic pready,  // apb ready
  output logic pslverr,  // apb error on unmapped address
  input wire logic led_in,  // isolated led input, high when current flows
  input wire logic vcc1_uv_in,  // vcc1 below falling supply_fault_n threshold
  input wire logic vcc2_uv_fall_in,  // vcc2 below falling supply_fault_n threshold
  input wire logic vcc2_uv_rise_in,  // vcc2 above rising supply_fault_n threshold
  input wire logic vcc2_ov_in,  // vcc2 above over-voltage threshold
  input wire logic span_ok_in,  // secondary span above about 6 V
  input wire logic feedback_rx_in,  // heartbeat seen by primary receiver
  input wire logic desat_in,  // collector sense above 9.1 V
  input wire logic gate_below_clamp_in,  // sensed gate below clamp threshold
  input wire logic pwm_in,  // regulator pwm, same clock domain
  output logic supply_fault_n_o,  // supply flag drive value
  output logic supply_fault_n_oe,  // supply flag pulled low when high
  output logic desat_fault_n_o,  // desat flag drive value
  output logic desat_fault_n_oe,  // desat flag pulled low when high
  output logic primary_switch_drive,  // flyback primary switch gate
  output logic comp_pull_low,  // compensation node pulled low
  output logic gate_out,  // main gate output level
  output logic gate_out_oe,  // main gate output enable
  output logic soft_shutdown_out,  // soft shutdown level (sinks)
  output logic soft_shutdown_oe,  // soft shutdown enable
  output logic miller_clamp_out,  // miller clamp pull-down on
  output logic feedback_emitter  // secondary heartbeat emitter
);

  logic [8:0] raw_in;
  logic [8:0] sync_in;
  logic led_s;
  logic vcc1_uv_s;
  logic uv_fall_s;
  logic uv_rise_s;
  logic ov_s;
  logic span_ok_s;
  logic fb_rx_s;
  logic desat_s;
  logic below_clamp_s;

  assign raw_in = {gate_below_clamp_in, desat_in, feedback_rx_in, span_ok_in, vcc2_ov_in,
                   vcc2_uv_rise_in, vcc2_uv_fall_in, vcc1_uv_in, led_in};

  in_sync #(.W(9)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .d(raw_in),
    .q(sync_in)
  );

  assign {below_clamp_s, desat_s, fb_rx_s, span_ok_s, ov_s,
          uv_rise_s, uv_fall_s, vcc1_uv_s, led_s} = sync_in;

  // apb slave: zero wait states
  logic [11:0] ext_blank_q;
  logic [31:0] prdata_q;
  logic [31:0] status_w;
  logic addr_ok;
  logic apb_wr;

  assign addr_ok = (paddr == CTRL_OFS) || (paddr == STATUS_OFS);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;
  assign prdata = prdata_q;
  assign apb_wr = psel && penable && pwrite && (paddr == CTRL_OFS);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_blank_q <= EXT_BLANK_RST;
    end else if (ce && apb_wr) begin
      ext_blank_q <= pwdata[CTRL_EXT_BLANK_LSB +: CTRL_EXT_BLANK_W];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (ce && psel && !penable) begin
      if (paddr == CTRL_OFS) begin
        prdata_q <= {20'h00000, ext_blank_q};
      end else if (paddr == STATUS_OFS) begin
        prdata_q <= status_w;
      end else begin
        prdata_q <= 32'h0000_0000;
      end
    end
  end

  // vcc2 under-voltage lockout with hysteresis
  logic uv_lock_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      uv_lock_q <= 1'b1;
    end else if (ce) begin
      if (uv_fall_s) begin
        uv_lock_q <= 1'b1;
      end else if (uv_rise_s) begin
        uv_lock_q <= 1'b0;
      end
    end
  end

  // secondary heartbeat emitter
  logic [11:0] hb_cnt_q;
  logic hb_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hb_cnt_q <= 12'h000;
      hb_q <= 1'b0;
    end else if (ce) begin
      if (!span_ok_s) begin
        hb_cnt_q <= 12'h000;
        hb_q <= 1'b0;
      end else if (hb_cnt_q == HB_HALF_CYC - 12'h001) begin
        hb_cnt_q <= 12'h000;
        hb_q <= !hb_q;
      end else begin
        hb_cnt_q <= hb_cnt_q + 12'h001;
      end
    end
  end

  assign feedback_emitter = hb_q;

  // primary heartbeat watchdog, armed by the first pulse seen
  logic fb_d1_q;
  logic fb_edge;
  logic hb_armed_q;
  logic [11:0] wd_q;
  logic fb_fault_q;

  assign fb_edge = fb_rx_s && !fb_d1_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fb_d1_q <= 1'b0;
      hb_armed_q <= 1'b0;
      wd_q <= 12'h000;
    end else if (ce) begin
      fb_d1_q <= fb_rx_s;
      if (fb_edge) begin
        hb_armed_q <= 1'b1;
        wd_q <= 12'h000;
      end else if (hb_armed_q && !fb_fault_q) begin
        wd_q <= wd_q + 12'h001;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fb_fault_q <= 1'b0;
    end else if (ce && hb_armed_q && !fb_edge && wd_q == HB_TIMEOUT_CYC - 12'h001) begin
      fb_fault_q <= 1'b1;
    end
  end

  // short-circuit sequencing
  drv_state_t state_q;
  logic [12:0] cnt_q;
  logic [12:0] blank_total;
  logic sc_active;

  assign blank_total = BLANK_INT_CYC + {1'b0, ext_blank_q};
  assign sc_active = (state_q == ST_MUTE) || (state_q == ST_RSTW);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_OFF;
      cnt_q <= 13'h0000;
    end else if (ce) begin
      case (state_q)
        ST_OFF: begin
          cnt_q <= 13'h0000;
          if (led_s && !uv_lock_q) begin
            state_q <= ST_BLANK;
          end
        end
        ST_BLANK: begin
          if (!led_s || uv_lock_q) begin
            state_q <= ST_OFF;
          end else if (cnt_q >= blank_total - 13'h0001) begin
            state_q <= ST_ON;
          end else begin
            cnt_q <= cnt_q + 13'h0001;
          end
        end
        ST_ON: begin
          cnt_q <= 13'h0000;
          if (desat_s) begin
            state_q <= ST_MUTE;
          end else if (!led_s || uv_lock_q) begin
            state_q <= ST_OFF;
          end
        end
        ST_MUTE: begin
          if (cnt_q >= MUTE_CYC - 13'h0001) begin
            state_q <= ST_RSTW;
            cnt_q <= 13'h0000;
          end else begin
            cnt_q <= cnt_q + 13'h0001;
          end
        end
        ST_RSTW: begin
          if (led_s) begin
            cnt_q <= 13'h0000;
          end else if (cnt_q >= FLT_RESET_CYC - 13'h0001) begin
            state_q <= ST_OFF;
            cnt_q <= 13'h0000;
          end else begin
            cnt_q <= cnt_q + 13'h0001;
          end
        end
        default: begin
          state_q <= ST_OFF;
          cnt_q <= 13'h0000;
        end
      endcase
    end
  end

  // gate, clamp and soft shutdown; over-voltage deliberately not used here
  logic gate_q;
  logic clamp_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_q <= 1'b0;
    end else if (ce) begin
      gate_q <= led_s && !uv_lock_q && !sc_active;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clamp_q <= 1'b0;
    end else if (ce) begin
      clamp_q <= below_clamp_s;
    end
  end

  assign gate_out = gate_q;
  assign gate_out_oe = !sc_active;
  assign soft_shutdown_out = 1'b0;
  assign soft_shutdown_oe = sc_active;
  assign miller_clamp_out = clamp_q;

  // primary switch drive and compensation
  logic psd_q;
  logic comp_low_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      psd_q <= 1'b0;
      comp_low_q <= 1'b0;
    end else if (ce) begin
      psd_q <= pwm_in && !ov_s && !fb_fault_q;
      comp_low_q <= fb_fault_q;
    end
  end

  assign primary_switch_drive = psd_q;
  assign comp_pull_low = comp_low_q;

  // status flags, open drain
  logic sup_flag_q;
  logic desat_flag_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sup_flag_q <= 1'b0;
      desat_flag_q <= 1'b0;
    end else if (ce) begin
      sup_flag_q <= vcc1_uv_s || uv_lock_q || ov_s || fb_fault_q;
      desat_flag_q <= sc_active || fb_fault_q;
    end
  end

  assign supply_fault_n_o = 1'b0;
  assign desat_fault_n_o = 1'b0;
  assign supply_fault_n_oe = sup_flag_q;
  assign desat_fault_n_oe = desat_flag_q;

  always_comb begin
    status_w = 32'h0000_0000;
    status_w[ST_UV_LOCK_BIT] = uv_lock_q;
    status_w[ST_VCC1_UV_BIT] = vcc1_uv_s;
    status_w[ST_OV_BIT] = ov_s;
    status_w[ST_FB_FAULT_BIT] = fb_fault_q;
    status_w[ST_SC_BIT] = sc_active;
    status_w[ST_HB_ARMED_BIT] = hb_armed_q;
    status_w[ST_STATE_LSB +: 3] = state_q;
    status_w[ST_GATE_BIT] = gate_q;
  end

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_fb_latched: assert property (fb_fault_q |=> fb_fault_q)
    else $error("feedback fault did not stay latched");
  a_fb_both_flags: assert property (ce && fb_fault_q |=> supply_fault_n_oe
                                  && desat_fault_n_oe && comp_pull_low && !primary_switch_drive)
    else $error("feedback fault did not pull flags and drive low");
  a_ov_psd_off: assert property (ce && ov_s |=> !primary_switch_drive)
    else $error("switch drive active during over-voltage");
  a_uv_gate_low: assert property (ce && uv_lock_q |=> !gate_out)
    else $error("gate high under lockout");
  a_clamp_follow: assert property (ce && below_clamp_s |=> miller_clamp_out)
    else $error("clamp not on below threshold");
  a_blank_full: assert property (state_q == ST_ON && $past(state_q) == ST_BLANK
                                 |-> $past(cnt_q) >= blank_total - 13'h0001)
    else $error("blanking ended early");
  a_trip_hiz: assert property (ce && state_q == ST_ON && desat_s
                               |=> !gate_out_oe && soft_shutdown_oe ##1 desat_fault_n_oe)
    else $error("desat trip did not shut down");
  a_mute_hold: assert property (ce && state_q == ST_MUTE && cnt_q == 13'h0000
                                |-> !gate_out_oe [*8])
    else $error("gate enabled during mute");
  a_release_sc: assert property (ce && $fell(sc_active) |-> !soft_shutdown_oe
                                 && gate_out_oe ##1 (!desat_fault_n_oe || fb_fault_q))
    else $error("fault not released on reset condition");
  a_normal_hiz: assert property (ce && !vcc1_uv_s && !uv_lock_q && !ov_s && !fb_fault_q
                                 && !sc_active |=> !supply_fault_n_oe && !desat_fault_n_oe)
    else $error("status flag driven with no fault");

  c_desat_trip: cover property (state_q == ST_ON ##1 state_q == ST_MUTE);
  c_sc_cleared: cover property (state_q == ST_RSTW ##1 state_q == ST_OFF);
  c_fb_fault: cover property ($rose(fb_fault_q));
  c_ov_event: cover property ($rose(ov_s) && gate_q);

endmodule

/* fault_sup_pkg.sv */
package fault_sup_pkg;

  localparam int CLK_PERIOD_NS = 10;

  // timing figures in ns, cycle counts derived from the 10 ns clock
  localparam int T_BLANK_INT_NS = 500;
  localparam int T_MUTE_NS = 3000;
  localparam int T_FLT_RESET_NS = 2000;
  localparam int T_HB_HALF_NS = 5000;
  localparam int T_HB_TIMEOUT_NS = 40000;

  localparam logic [12:0] BLANK_INT_CYC =
    13'((T_BLANK_INT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [12:0] MUTE_CYC = 13'((T_MUTE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [12:0] FLT_RESET_CYC =
    13'((T_FLT_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [11:0] HB_HALF_CYC = 12'(T_HB_HALF_NS / CLK_PERIOD_NS);
  localparam logic [11:0] HB_TIMEOUT_CYC = 12'(T_HB_TIMEOUT_NS / CLK_PERIOD_NS);

  // apb register map
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] STATUS_OFS = 12'h004;
  localparam logic [11:0] EXT_BLANK_RST = 12'h000;
  localparam int CTRL_EXT_BLANK_LSB = 0;
  localparam int CTRL_EXT_BLANK_W = 12;

  // status field positions
  localparam int ST_UV_LOCK_BIT = 0;
  localparam int ST_VCC1_UV_BIT = 1;
  localparam int ST_OV_BIT = 2;
  localparam int ST_FB_FAULT_BIT = 3;
  localparam int ST_SC_BIT = 4;
  localparam int ST_HB_ARMED_BIT = 5;
  localparam int ST_STATE_LSB = 6;
  localparam int ST_GATE_BIT = 9;

  typedef enum logic [2:0] {
    ST_OFF = 3'b000,
    ST_BLANK = 3'b001,
    ST_ON = 3'b010,
    ST_MUTE = 3'b011,
    ST_RSTW = 3'b100
  } drv_state_t;

endpackage

/* in_sync.sv */
`timescale 1ns/1ns
module in_sync #(
  parameter int W = 1
) (
  input wire logic pclk,  // clock
  input wire logic presetn,  // async reset, active low
  input wire logic ce,  // clock enable
  input wire logic [W-1:0] d,  // asynchronous inputs
  output logic [W-1:0] q  // synchronised outputs
);
  logic [W-1:0] meta_q;

  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        meta_q[i] <= 1'b0;
        q[i] <= 1'b0;
      end else if (ce) begin
        meta_q[i] <= d[i];
        q[i] <= meta_q[i];
      end
    end
  end
endmodule

/* host_mcu.sv */
`timescale 1ns/1ns
module host_mcu (
  input wire logic led_cmd,  // bench asks for led current
  input wire logic supply_fault_n_o,  // supply flag drive value
  input wire logic supply_fault_n_oe,  // supply flag enable
  input wire logic desat_fault_n_o,  // desat flag drive value
  input wire logic desat_fault_n_oe,  // desat flag enable
  output logic led_in,  // led current to the device
  output logic supply_flag_n,  // supply flag level at the pin
  output logic desat_flag_n  // desat flag level at the pin
);
  // led follows the bench command as is; holding it off after mute is left to the bench
  assign led_in = led_cmd;
  // open-drain flags with external pull-ups: a released flag reads high
  assign supply_flag_n = supply_fault_n_oe ? supply_fault_n_o : 1'h1;
  assign desat_flag_n = desat_fault_n_oe ? desat_fault_n_o : 1'h1;
endmodule

/* test_fault_supervisor.sv */
`timescale 1ns/1ns
module test_fault_supervisor import fault_sup_pkg::*;;
  logic pclk = 1'h0, presetn = 1'h0, ce = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, led_cmd = 1'h0, led_in, vcc1_uv_in = 1'h0, vcc2_uv_fall_in = 1'h1;
  logic vcc2_uv_rise_in = 1'h0, vcc2_ov_in = 1'h0, span_ok_in = 1'h1, fb_loop = 1'h1;
  logic feedback_rx_in, desat_in = 1'h0, gate_below_clamp_in = 1'h0, pwm_in = 1'h1, e0;
  logic supply_fault_n_o, supply_fault_n_oe, desat_fault_n_o, desat_fault_n_oe;
  logic primary_switch_drive, comp_pull_low, gate_out, gate_out_oe, soft_shutdown_out;
  logic soft_shutdown_oe, miller_clamp_out, feedback_emitter, supply_flag_n, desat_flag_n;
  int fail_count = 0;
  int check_count = 0;

  // heartbeat loopback; cutting it models a dead feedback channel
  assign feedback_rx_in = fb_loop ? feedback_emitter : 1'h0;

  fault_supervisor uut (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .led_in, .vcc1_uv_in, .vcc2_uv_fall_in, .vcc2_uv_rise_in,
    .vcc2_ov_in, .span_ok_in, .feedback_rx_in, .desat_in, .gate_below_clamp_in, .pwm_in,
    .supply_fault_n_o, .supply_fault_n_oe, .desat_fault_n_o, .desat_fault_n_oe,
    .primary_switch_drive, .comp_pull_low, .gate_out, .gate_out_oe, .soft_shutdown_out,
    .soft_shutdown_oe, .miller_clamp_out, .feedback_emitter);

  host_mcu host (.led_cmd, .supply_fault_n_o, .supply_fault_n_oe, .desat_fault_n_o,
    .desat_fault_n_oe, .led_in, .supply_flag_n, .desat_flag_n);

  initial begin
    forever #5 pclk = ~pclk;
  end

  task wrap_up;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask

  task tick(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask

  task done(input string nm);
    $display("test %s finished", nm);
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'h1 && k < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (pready !== 1'h1) begin
      fail_count++;
      $display("unexpected pready: expected 1 seen %b", pready);
      wrap_up();
    end
  endtask

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    led_cmd <= 1'h1;
    tick(6);
    chk("gate_out", 0, gate_out);
    chk("supply flag", 0, supply_flag_n);
    chk("desat flag", 1, desat_flag_n);
    @(posedge pclk);
    led_cmd <= 1'h0;
    vcc2_uv_fall_in <= 1'h0;
    vcc2_uv_rise_in <= 1'h1;
    tick(6);
    chk("supply flag", 1, supply_flag_n);
    chk("desat flag", 1, desat_flag_n);
    done("power up");
    apb(1'h1, CTRL_OFS, 32'ha);
    apb(1'h0, CTRL_OFS, 32'h0);
    chk("ctrl", 32'ha, rd);
    apb(1'h0, STATUS_OFS, 32'h0);
    chk("status lockout", 0, rd[ST_UV_LOCK_BIT]);
    apb(1'h0, 12'h008, 32'h0);
    chk("pslverr", 1, err);
    chk("unmapped read", 0, rd);
    chk("pready", 1, pready);
    done("registers");
    // desat held from turn-on: must not trip before 50 + 10 cycles of blanking
    @(posedge pclk);
    led_cmd <= 1'h1;
    desat_in <= 1'h1;
    tick(55);
    chk("desat flag", 1, desat_flag_n);
    tick(15);
    chk("desat flag", 0, desat_flag_n);
    chk("supply flag", 1, supply_flag_n);
    chk("soft shutdown oe", 1, soft_shutdown_oe);
    chk("soft shutdown", 0, soft_shutdown_out);
    chk("gate_out_oe", 0, gate_out_oe);
    @(posedge pclk);
    desat_in <= 1'h0;
    tick(80);
    chk("gate_out_oe", 0, gate_out_oe);
    @(posedge pclk);
    led_cmd <= 1'h0;
    tick(350);
    chk("desat flag", 0, desat_flag_n);
    chk("gate_out_oe", 0, gate_out_oe);
    // one stray led pulse while waiting restarts the whole reset interval
    @(posedge pclk);
    led_cmd <= 1'h1;
    @(posedge pclk);
    led_cmd <= 1'h0;
    tick(100);
    chk("desat flag", 0, desat_flag_n);
    tick(110);
    chk("desat flag", 1, desat_flag_n);
    chk("soft shutdown oe", 0, soft_shutdown_oe);
    chk("gate_out_oe", 1, gate_out_oe);
    @(posedge pclk);
    led_cmd <= 1'h1;
    tick(5);
    chk("gate_out", 1, gate_out);
    done("short circuit");
    @(posedge pclk);
    vcc2_ov_in <= 1'h1;
    gate_below_clamp_in <= 1'h1;
    tick(6);
    chk("supply flag", 0, supply_flag_n);
    chk("desat flag", 1, desat_flag_n);
    chk("switch drive", 0, primary_switch_drive);
    chk("gate_out", 1, gate_out);
    chk("clamp", 1, miller_clamp_out);
    @(posedge pclk);
    vcc1_uv_in <= 1'h1;
    @(posedge pclk);
    vcc2_ov_in <= 1'h0;
    gate_below_clamp_in <= 1'h0;
    led_cmd <= 1'h0;
    tick(6);
    chk("supply flag", 0, supply_flag_n);
    chk("switch drive", 1, primary_switch_drive);
    chk("clamp", 0, miller_clamp_out);
    chk("gate_out", 0, gate_out);
    @(posedge pclk);
    vcc1_uv_in <= 1'h0;
    tick(6);
    chk("supply flag", 1, supply_flag_n);
    done("supply faults");
    // with the clock enable low nothing moves, not even the input synchronisers
    @(posedge pclk);
    ce <= 1'h0;
    led_cmd <= 1'h1;
    tick(5);
    chk("frozen gate_out", 0, gate_out);
    @(posedge pclk);
    ce <= 1'h1;
    led_cmd <= 1'h0;
    tick(1);
    done("clock enable");
    e0 = feedback_emitter;
    tick(501);
    chk("heartbeat toggle", 1, feedback_emitter !== e0);
    @(posedge pclk);
    fb_loop <= 1'h0;
    tick(4100);
    chk("supply flag", 0, supply_flag_n);
    chk("desat flag", 0, desat_flag_n);
    chk("switch drive", 0, primary_switch_drive);
    chk("comp pull low", 1, comp_pull_low);
    @(posedge pclk);
    fb_loop <= 1'h1;
    tick(1100);
    chk("comp pull low", 1, comp_pull_low);
    chk("desat flag", 0, desat_flag_n);
    // primary power cycle is the only way out of the channel fault
    @(posedge pclk);
    presetn <= 1'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    tick(10);
    chk("comp pull low", 0, comp_pull_low);
    chk("supply flag", 1, supply_flag_n);
    chk("desat flag", 1, desat_flag_n);
    done("feedback channel");
    wrap_up();
  end
endmodule
